// ===== rtl/ipf_pkg.sv
// Constants shared by the interrupt priority field block.
package ipf_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;
   localparam int unsigned REG_W = 16;
   localparam int unsigned FLD_W = 3;
   localparam int unsigned NSRC = 4;
   localparam int unsigned SRC_W = 2;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_OC5 = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_PMP = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_I2C2 = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_STAT = 12'h00c;

   // ---------------------------------------------------------------
   // Source indices, their register and field position
   // ---------------------------------------------------------------
   localparam int unsigned SRC_OC5 = 0;
   localparam int unsigned SRC_PMP = 1;
   localparam int unsigned SRC_I2C_CTRL = 2;
   localparam int unsigned SRC_I2C_TGT = 3;
   localparam logic [ADDR_W-1:0] SRC_OFF [NSRC] = '{OFF_OC5, OFF_PMP, OFF_I2C2, OFF_I2C2};
   localparam int unsigned SRC_POS [NSRC] = '{4, 4, 8, 4};

   // ---------------------------------------------------------------
   // Field codes and reset value
   // ---------------------------------------------------------------
   localparam logic [FLD_W-1:0] LEVEL_OFF = 3'h0;
   localparam logic [FLD_W-1:0] LEVEL_MIN = 3'h1;
   localparam logic [FLD_W-1:0] LEVEL_MAX = 3'h7;
   localparam logic [FLD_W-1:0] FLD_RESET = 3'h4;

   // ---------------------------------------------------------------
   // Status register layout
   // ---------------------------------------------------------------
   localparam int unsigned STAT_PEND_POS = 0;
   localparam int unsigned STAT_LVL_POS = 1;
   localparam int unsigned STAT_SRC_POS = 4;
   localparam int unsigned STAT_REQ_POS = 8;

   // ---------------------------------------------------------------
   // Bus slave states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } ipf_state_t;

endpackage : ipf_pkg

// ===== rtl/ipf_source_gate.sv
// Per-source gate that turns a priority field and a request into a level.
`timescale 1ns/100ps
`default_nettype none

module ipf_source_gate
   import ipf_pkg::*;
(
   input wire logic [ipf_pkg::FLD_W-1:0] field,
   input wire logic req,
   output logic active,
   output logic [ipf_pkg::FLD_W-1:0] level
);

   // ---------------------------------------------------------------
   // Level mapping
   // ---------------------------------------------------------------

   // The code is the level itself, so 001 is the lowest and 111 the highest.
   // A code of zero never presents the source, whatever its request does.
   always_comb begin
      active = req && (field != LEVEL_OFF);
      level = active ? field : LEVEL_OFF;
   end

endmodule : ipf_source_gate
`default_nettype wire

// ===== rtl/ipf_top.sv
// APB register slice holding four interrupt priority fields and their arbiter.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module ipf_top
   import ipf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ipf_pkg::ADDR_W-1:0] paddr,
   input wire logic [ipf_pkg::DATA_W-1:0] pwdata,
   input wire logic [ipf_pkg::STRB_W-1:0] pstrb,
   output logic [ipf_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ipf_pkg::NSRC-1:0] src_req,
   output logic [ipf_pkg::FLD_W-1:0] output_compare5_level,
   output logic [ipf_pkg::FLD_W-1:0] parallel_port_level,
   output logic [ipf_pkg::FLD_W-1:0] i2c2_controller_event_level,
   output logic [ipf_pkg::FLD_W-1:0] i2c2_target_event_level,
   output logic irq_pending,
   output logic [ipf_pkg::FLD_W-1:0] irq_level,
   output logic [ipf_pkg::SRC_W-1:0] irq_source
);

   import ipf_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   ipf_state_t state_r;
   ipf_state_t state_nxt;
   logic [FLD_W-1:0] fld_r [NSRC];
   logic [DATA_W-1:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_pending_r;
   logic [FLD_W-1:0] irq_level_r;
   logic [SRC_W-1:0] irq_source_r;
   logic [NSRC-1:0] gate_active;
   logic [FLD_W-1:0] gate_level [NSRC];
   logic access_start;
   logic access_commit;
   logic wr_commit;
   logic hit_oc5;
   logic hit_pmp;
   logic hit_i2c2;
   logic hit_stat;
   logic addr_mapped;
   logic [REG_W-1:0] rd_field_word;
   logic [DATA_W-1:0] rd_word;
   logic win_pending_nxt;
   logic [FLD_W-1:0] win_level_nxt;
   logic [SRC_W-1:0] win_source_nxt;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------

   // An access starts when the access phase is first seen and the slave
   // has not yet answered; it commits on the edge where pready is high.
   assign access_start = psel && penable && (state_r == ST_IDLE);
   assign access_commit = psel && penable && pready_r;
   assign wr_commit = access_commit && pwrite;

   // Decode on the whole address, so an unaligned address is unmapped.
   assign hit_oc5 = (paddr == OFF_OC5);
   assign hit_pmp = (paddr == OFF_PMP);
   assign hit_i2c2 = (paddr == OFF_I2C2);
   assign hit_stat = (paddr == OFF_STAT);
   assign addr_mapped = hit_oc5 || hit_pmp || hit_i2c2 || hit_stat;

   // ---------------------------------------------------------------
   // Bus slave state machine
   // ---------------------------------------------------------------

   // One wait state: pready rises one cycle into the access phase.
   // This buys a registered read path at the cost of one cycle per access.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (access_start) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Ready and error are pulses of one cycle, aligned to the answer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= access_start;
         pslverr_r <= access_start && !addr_mapped;
      end
   end

   // ---------------------------------------------------------------
   // Priority fields
   // ---------------------------------------------------------------

   // Each field is written only from its own bits and only when the byte
   // lane that holds it is strobed; every other bit has no storage at all,
   // so writes to unimplemented positions cannot have any effect.
   for (genvar i = 0; i < NSRC; i++) begin : g_field
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fld_r[i] <= FLD_RESET;
         end else if (wr_commit && (paddr == SRC_OFF[i]) && pstrb[SRC_POS[i] / 8]) begin
            fld_r[i] <= pwdata[SRC_POS[i] +: FLD_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------

   // Gather the fields of the addressed register into a zeroed word.
   always_comb begin
      rd_field_word = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (paddr == SRC_OFF[i]) begin
            rd_field_word[SRC_POS[i] +: FLD_W] = fld_r[i];
         end
      end
   end

   // Status shows the current winner and the raw requests; it is read only.
   always_comb begin
      rd_word = '0;
      if (hit_stat) begin
         rd_word[STAT_PEND_POS] = irq_pending_r;
         rd_word[STAT_LVL_POS +: FLD_W] = irq_level_r;
         rd_word[STAT_SRC_POS +: SRC_W] = irq_source_r;
         rd_word[STAT_REQ_POS +: NSRC] = src_req;
      end else if (addr_mapped) begin
         rd_word[REG_W-1:0] = rd_field_word;
      end
   end

   // Read data is loaded with pready and cleared otherwise, so an
   // unmapped address or a write answers with zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (access_start && !pwrite) begin
         prdata_r <= rd_word;
      end else begin
         prdata_r <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Source gates
   // ---------------------------------------------------------------

   // One gate per source drops requests whose field reads as disabled.
   for (genvar i = 0; i < NSRC; i++) begin : g_gate
      ipf_source_gate u_gate (
         .field(fld_r[i]),
         .req(src_req[i]),
         .active(gate_active[i]),
         .level(gate_level[i])
      );
   end

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------

   // The highest level wins; on a tie the lower source index wins since
   // only a strictly higher level replaces the current choice.
   always_comb begin
      win_pending_nxt = 1'b0;
      win_level_nxt = LEVEL_OFF;
      win_source_nxt = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (gate_active[i] && (gate_level[i] > win_level_nxt)) begin
            win_pending_nxt = 1'b1;
            win_level_nxt = gate_level[i];
            win_source_nxt = SRC_W'(i);
         end
      end
   end

   // The winner is registered, so it lags its inputs by one clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pending_r <= 1'b0;
         irq_level_r <= LEVEL_OFF;
         irq_source_r <= '0;
      end else begin
         irq_pending_r <= win_pending_nxt;
         irq_level_r <= win_level_nxt;
         irq_source_r <= win_source_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   // All outputs come straight from flip-flops.
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign output_compare5_level = fld_r[SRC_OC5];
   assign parallel_port_level = fld_r[SRC_PMP];
   assign i2c2_controller_event_level = fld_r[SRC_I2C_CTRL];
   assign i2c2_target_event_level = fld_r[SRC_I2C_TGT];
   assign irq_pending = irq_pending_r;
   assign irq_level = irq_level_r;
   assign irq_source = irq_source_r;

endmodule : ipf_top
`default_nettype wire

// ===== testbench/ipf_top_sva.sv
// Port checker for the interrupt priority field block.
`timescale 1ns/100ps
`default_nettype none
module ipf_top_sva
   import ipf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ipf_pkg::ADDR_W-1:0] paddr,
   input wire logic [ipf_pkg::DATA_W-1:0] pwdata,
   input wire logic [ipf_pkg::STRB_W-1:0] pstrb,
   input wire logic [ipf_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic [ipf_pkg::NSRC-1:0] src_req,
   input wire logic [ipf_pkg::FLD_W-1:0] output_compare5_level,
   input wire logic [ipf_pkg::FLD_W-1:0] parallel_port_level,
   input wire logic [ipf_pkg::FLD_W-1:0] i2c2_controller_event_level,
   input wire logic [ipf_pkg::FLD_W-1:0] i2c2_target_event_level,
   input wire logic irq_pending,
   input wire logic [ipf_pkg::FLD_W-1:0] irq_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic [2:0] wr_fld;
   // Completed access and the field slice of the write data.
   assign acc = psel && penable && pready;
   assign wr_fld = pwdata[6:4];
   property p_unimpl;
      acc && !pwrite && paddr != OFF_STAT |-> (prdata & ~(paddr == OFF_I2C2 ? 32'h770 : 32'h70)) == '0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("reserved bit read as one");
   property p_rst;
      $rose(presetn) |-> {output_compare5_level, parallel_port_level, i2c2_controller_event_level,
                          i2c2_target_event_level} == {4{FLD_RESET}};
   endproperty
   a_rst: assert property (p_rst) else $error("field not at reset level");
   property p_wr;
      acc && pwrite && paddr == OFF_OC5 && pstrb[0] |=> output_compare5_level == $past(wr_fld);
   endproperty
   a_wr: assert property (p_wr) else $error("written field not stored");
   property p_hold;
      !(acc && pwrite) |=> $stable(output_compare5_level);
   endproperty
   a_hold: assert property (p_hold) else $error("field changed without write");
   property p_max;
      src_req[0] && output_compare5_level == LEVEL_MAX |=> irq_pending && irq_level == LEVEL_MAX;
   endproperty
   a_max: assert property (p_max) else $error("top code not at top level");
   property p_off;
      src_req == 4'h1 && output_compare5_level == LEVEL_OFF |=> !irq_pending;
   endproperty
   a_off: assert property (p_off) else $error("disabled source presented");
   property p_lin;
      src_req == 4'h1 |=> irq_level == $past(output_compare5_level);
   endproperty
   a_lin: assert property (p_lin) else $error("level not equal to code");
   // Main scenarios: a field write, a top-level request and a gated request.
   c_wr: cover property (acc && pwrite);
   c_max: cover property (irq_pending && irq_level == LEVEL_MAX);
   c_off: cover property (src_req == 4'h1 && output_compare5_level == LEVEL_OFF);
endmodule : ipf_top_sva
bind ipf_top ipf_top_sva u_sva (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the interrupt priority field block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ipf_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_pending, er;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic [STRB_W-1:0] pstrb = '0;
   logic [NSRC-1:0] src_req = '0;
   logic [FLD_W-1:0] l0, l1, l2, l3, irq_level;
   logic [FLD_W-1:0] f [NSRC];
   logic [SRC_W-1:0] irq_source;
   int err_total = 0, tests_run = 0;
   ipf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_req(src_req), .output_compare5_level(l0), .parallel_port_level(l1),
      .i2c2_controller_event_level(l2), .i2c2_target_event_level(l3), .irq_pending(irq_pending),
      .irq_level(irq_level), .irq_source(irq_source));
   // Free-running bus clock.
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // One bus transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         err_total++;
         end_sim();
      end
   endtask : apb
   // Expected register word from the bench's copy of the fields.
   function automatic logic [31:0] ev(int i);
      case (i)
         0: ev = {25'h0, f[0], 4'h0};
         1: ev = {25'h0, f[1], 4'h0};
         default: ev = {21'h0, f[2], 1'b0, f[3], 4'h0};
      endcase
   endfunction : ev
   initial begin
      int i, k;
      logic [31:0] d;
      void'($urandom(9));
      foreach (f[j]) f[j] = FLD_RESET;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 3; i++) begin
         apb(1'b0, 12'(i * 4), '0, '0);
         chk("reset word", ev(i), rd);
      end
      $display("test reset done");
      // Random whole-word writes, each read back; reserved bits get ones too.
      for (k = 0; k < 30; k++) begin
         i = $urandom_range(2);
         d = $urandom;
         apb(1'b1, 12'(i * 4), d, 4'hf);
         f[i == 2 ? 3 : i] = d[6:4];
         if (i == 2) f[2] = d[10:8];
         apb(1'b0, 12'(i * 4), '0, '0);
         chk("readback", ev(i), rd);
         chk("levels", {20'h0, f[0], f[1], f[2], f[3]}, {20'h0, l0, l1, l2, l3});
      end
      apb(1'b1, OFF_OC5, 32'hffff, 4'h0);
      chk("no strobe", {29'h0, f[0]}, {29'h0, l0});
      apb(1'b0, 12'h010, '0, '0);
      chk("unmapped", 32'h1, {31'h0, er});
      $display("test registers done");
      // Every code on one requesting source.
      for (k = 0; k < 8; k++) begin
         apb(1'b1, OFF_OC5, 32'(k) << 4, 4'h1);
         src_req <= 4'h1;
         repeat (3) @(posedge pclk);
         #1;
         chk("pending", {31'h0, k != 0}, {31'h0, irq_pending});
         chk("level", 32'(k), {29'h0, irq_level});
         chk("source", 32'h0, {30'h0, irq_source});
      end
      // Both second-port sources at the top level: the tie goes to the lower index.
      apb(1'b1, OFF_I2C2, 32'h0770, 4'h3);
      src_req <= 4'hc;
      repeat (3) @(posedge pclk);
      #1;
      chk("tie source", 32'h2, {30'h0, irq_source});
      chk("tie level", 32'h7, {29'h0, irq_level});
      apb(1'b0, OFF_STAT, '0, '0);
      chk("status", 32'h00000c2f, rd);
      chk("status error", 32'h0, {31'h0, er});
      $display("test arbiter done");
      end_sim();
   end
endmodule : testbench
`default_nettype wire
